// ---- verilog/fpg_defs.vh ----
`ifndef FPG_DEFS_VH
`define FPG_DEFS_VH

// Timing
`define FPG_CLK_MHZ 200
`define FPG_DB_NS 5000
`define FPG_DB_RST_NS 7000
`define FPG_DB_CYC ((`FPG_DB_NS * `FPG_CLK_MHZ + 999) / 1000)
`define FPG_DB_RST_CYC ((`FPG_DB_RST_NS * `FPG_CLK_MHZ + 999) / 1000)

// Register indexes, byte address is four times these
`define FPG_IDX_P0_DATA 14'h0080
`define FPG_IDX_P1_DATA 14'h0088
`define FPG_IDX_P2_DATA 14'h0090
`define FPG_IDX_P3_DATA 14'h0098
`define FPG_IDX_P0_DIR 14'h0089
`define FPG_IDX_P1_DIR 14'h0091
`define FPG_IDX_P2_DIR 14'h0099
`define FPG_IDX_P3_DIR 14'h00A1
`define FPG_IDX_PCI 14'h00AE
`define FPG_IDX_P0_PU 14'h2F00
`define FPG_IDX_P1_PU 14'h2F01
`define FPG_IDX_P2_PU 14'h2F02
`define FPG_IDX_P3_PU 14'h2F03
`define FPG_IDX_P0_OD 14'h2F0C
`define FPG_IDX_P1_OD 14'h2F0D
`define FPG_IDX_P2_OD 14'h2F0E
`define FPG_IDX_P3_OD 14'h2F0F
`define FPG_IDX_P0_DB 14'h2F18
`define FPG_IDX_P1_DB 14'h2F19
`define FPG_IDX_P2_DB 14'h2F1A
`define FPG_IDX_P3_DB 14'h2F1B
`define FPG_IDX_ANALOG_SELECT_LOW 14'h2F50
`define FPG_IDX_ANALOG_SELECT_HIGH_I2C_ROUTE 14'h2F51
`define FPG_IDX_IRQ_STAT 14'h2F60
`define FPG_IDX_IRQ_EN 14'h2F61
`define FPG_IDX_IRQ_CLR 14'h2F62

// Reset values
`define FPG_RST_PORT 32'h0000_0000
`define FPG_RST_DB 32'h0004_0000
`define FPG_RST_BYTE 8'h00

// Field positions
`define FPG_RST_PIN 18
`define FPG_ANALOG_SELECT_HIGH_I2C_ROUTE_I2C 7
`define FPG_AN8_PIN 13
`define FPG_AN9_PIN 14
`define FPG_AN10_PIN 30
`define FPG_AN11_PIN 31
`define FPG_AN12_PIN 19
`define FPG_AN13_PIN 20
`define FPG_AN14_PIN 21

`endif

// ---- verilog/fpg_top.v ----
// Behaviour
// - Four ports of eight pins, each with data, direction, pull-up, drain, debounce.
// - Output pins drive the data bit; input pins read back the pin level.
// - Direction bit 0 is input, 1 output; reset clears all to input.
// - Pull-up bit 1 enables the pin pull-up; reset clears all.
// - Open-drain bit 1 selects open-drain, else push-pull; reset is push-pull.
// - Debounce bit 1 filters the input for about 5 us; 0 passes it.
// - Port 2 pin 2 used as external reset filters for about 7 us.
// - Debounce starts off for all pins except port 2 pin 2.
// - Any enabled port 0 pin toggling either way raises a pin-change request.
// - Pin-change enable bit 1 includes the port 0 pin, 0 excludes it.
// - Port selection bit 1 cuts the input buffer; input reads as 1.
// - First selection register bits enable analog channels 0..7 on port 0.
// - Second register bits 6..0 map channels 14..8 to P25,P24,P23,P37,P36,P16,P15.
// - Writing 1 to bits 6..0 of second register enables channels 8..14.
// - Second register bit 7 routes I2C to P0[7:6] at 0, P2[6:5] at 1.
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
`include "fpg_defs.vh"

module fpg_top #(
    parameter DB_CYC = `FPG_DB_CYC,
    parameter DB_RST_CYC = `FPG_DB_RST_CYC
) (
    input wire clk_sys,
    input wire rstn,
    input wire [15:0] paddr,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire [31:0] pin_in,
    output reg [31:0] pin_out_r,
    output reg [31:0] pin_oe_r,
    output reg [31:0] pin_pullup_r,
    output reg [31:0] pin_ibuf_off_r,
    output reg [14:0] analog_channel_r,
    output reg i2c_alt_route_r,
    input wire ext_reset_mode,
    input wire irq_ack,
    output reg irq_r
);

    // Per-port index tables, port 0 in the low slice
    localparam [55:0] IDX_DATA = {
        `FPG_IDX_P3_DATA,
        `FPG_IDX_P2_DATA,
        `FPG_IDX_P1_DATA,
        `FPG_IDX_P0_DATA
    };
    localparam [55:0] IDX_DIR = {
        `FPG_IDX_P3_DIR,
        `FPG_IDX_P2_DIR,
        `FPG_IDX_P1_DIR,
        `FPG_IDX_P0_DIR
    };
    localparam [55:0] IDX_PU = {
        `FPG_IDX_P3_PU,
        `FPG_IDX_P2_PU,
        `FPG_IDX_P1_PU,
        `FPG_IDX_P0_PU
    };
    localparam [55:0] IDX_OD = {
        `FPG_IDX_P3_OD,
        `FPG_IDX_P2_OD,
        `FPG_IDX_P1_OD,
        `FPG_IDX_P0_OD
    };
    localparam [55:0] IDX_DB = {
        `FPG_IDX_P3_DB,
        `FPG_IDX_P2_DB,
        `FPG_IDX_P1_DB,
        `FPG_IDX_P0_DB
    };

    // Eleven counter bits cover the long interval at this clock rate
    localparam integer LIM_N_I = DB_CYC - 1;
    localparam integer LIM_R_I = DB_RST_CYC - 1;
    localparam [10:0] LIM_N = LIM_N_I[10:0];
    localparam [10:0] LIM_R = LIM_R_I[10:0];

    reg [31:0] data_r;
    reg [31:0] dir_r;
    reg [31:0] pu_r;
    reg [31:0] od_r;
    reg [31:0] db_r;
    reg [7:0] pci_r;
    reg [7:0] analog_select_low_r;
    reg [7:0] analog_select_high_i2c_route_r;
    reg [7:0] stat_r;
    reg [7:0] stat_nxt;
    reg [7:0] irq_en_r;
    reg [31:0] samp_r;
    reg [7:0] prev_r;
    reg seen_r;
    reg [31:0] cut_w;
    reg [31:0] prdata_nxt;
    reg hit_nxt;
    wire [31:0] filt_w;
    wire [31:0] in_w;
    wire [31:0] port_rd_w;
    wire [7:0] ev_w;
    wire [7:0] clr_w;
    wire [13:0] idx;
    wire wr_en;
    // Separate loop indexes, one per process
    integer p;
    integer q;

    assign idx = paddr[15:2];
    // Write lands only on the completing access edge
    assign wr_en = psel && penable && pready && pwrite;

    // Input sampling, the pins are already in this clock domain
    always @(posedge clk_sys) begin
        if (!rstn) begin
            samp_r <= `FPG_RST_PORT;
        end else begin
            samp_r <= pin_in;
        end
    end

    // Per-pin debounce: new level taken only after it held the whole interval
    // Filter starts low, so a high pin with debounce on settles after one interval
    genvar g;
    generate
        for (g = 0; g < 32; g = g + 1) begin : g_pin
            reg [10:0] cnt_r;
            reg filt_r;
            wire [10:0] lim;
            assign lim = (g == `FPG_RST_PIN && ext_reset_mode) ? LIM_R : LIM_N;
            always @(posedge clk_sys) begin
                if (!rstn) begin
                    cnt_r <= 11'h000;
                    filt_r <= 1'b0;
                end else if (!db_r[g]) begin
                    cnt_r <= 11'h000;
                    filt_r <= samp_r[g];
                end else if (samp_r[g] == filt_r) begin
                    cnt_r <= 11'h000;
                end else if (cnt_r >= lim) begin
                    cnt_r <= 11'h000;
                    filt_r <= samp_r[g];
                end else begin
                    cnt_r <= cnt_r + 11'h001;
                end
            end
            assign filt_w[g] = filt_r;
        end
    endgenerate

    // Analog selection cuts the buffer of each listed pin
    always @* begin
        cut_w = 32'h0000_0000;
        cut_w[7:0] = analog_select_low_r;
        cut_w[`FPG_AN8_PIN] = analog_select_high_i2c_route_r[0];
        cut_w[`FPG_AN9_PIN] = analog_select_high_i2c_route_r[1];
        cut_w[`FPG_AN10_PIN] = analog_select_high_i2c_route_r[2];
        cut_w[`FPG_AN11_PIN] = analog_select_high_i2c_route_r[3];
        cut_w[`FPG_AN12_PIN] = analog_select_high_i2c_route_r[4];
        cut_w[`FPG_AN13_PIN] = analog_select_high_i2c_route_r[5];
        cut_w[`FPG_AN14_PIN] = analog_select_high_i2c_route_r[6];
    end

    assign in_w = filt_w | cut_w;
    // Outputs read back their latch, inputs the pin
    assign port_rd_w = (data_r & dir_r) | (in_w & ~dir_r);

    // Pin-change events on port 0
    always @(posedge clk_sys) begin
        if (!rstn) begin
            prev_r <= `FPG_RST_BYTE;
            seen_r <= 1'b0;
        end else begin
            prev_r <= in_w[7:0];
            seen_r <= 1'b1;
        end
    end

    // First cycle after reset has no valid previous sample
    assign ev_w = (in_w[7:0] ^ prev_r) & pci_r & {8{seen_r}};
    assign clr_w = (wr_en && idx == `FPG_IDX_IRQ_CLR) ? pwdata[7:0] : 8'h00;

    // A new event wins over a clear in the same cycle
    // Acknowledge drops every pending bit, not only the enabled ones
    always @* begin
        stat_nxt = stat_r & ~clr_w;
        if (irq_ack) begin
            stat_nxt = 8'h00;
        end
        stat_nxt = stat_nxt | ev_w;
    end

    always @(posedge clk_sys) begin
        if (!rstn) begin
            stat_r <= `FPG_RST_BYTE;
            irq_r <= 1'b0;
        end else begin
            stat_r <= stat_nxt;
            irq_r <= |(stat_r & irq_en_r);
        end
    end

    // Register writes
    always @(posedge clk_sys) begin
        if (!rstn) begin
            data_r <= `FPG_RST_PORT;
            dir_r <= `FPG_RST_PORT;
            pu_r <= `FPG_RST_PORT;
            od_r <= `FPG_RST_PORT;
            db_r <= `FPG_RST_DB;
            pci_r <= `FPG_RST_BYTE;
            analog_select_low_r <= `FPG_RST_BYTE;
            analog_select_high_i2c_route_r <= `FPG_RST_BYTE;
            irq_en_r <= `FPG_RST_BYTE;
        end else if (wr_en) begin
            for (q = 0; q < 4; q = q + 1) begin
                if (idx == IDX_DATA[q*14 +: 14]) begin
                    data_r[q*8 +: 8] <= pwdata[7:0];
                end
                if (idx == IDX_DIR[q*14 +: 14]) begin
                    dir_r[q*8 +: 8] <= pwdata[7:0];
                end
                if (idx == IDX_PU[q*14 +: 14]) begin
                    pu_r[q*8 +: 8] <= pwdata[7:0];
                end
                if (idx == IDX_OD[q*14 +: 14]) begin
                    od_r[q*8 +: 8] <= pwdata[7:0];
                end
                if (idx == IDX_DB[q*14 +: 14]) begin
                    db_r[q*8 +: 8] <= pwdata[7:0];
                end
            end

            // Upper write data bits are ignored, registers are one byte
            if (idx == `FPG_IDX_PCI) begin
                pci_r <= pwdata[7:0];
            end
            if (idx == `FPG_IDX_ANALOG_SELECT_LOW) begin
                analog_select_low_r <= pwdata[7:0];
            end
            if (idx == `FPG_IDX_ANALOG_SELECT_HIGH_I2C_ROUTE) begin
                analog_select_high_i2c_route_r <= pwdata[7:0];
            end
            if (idx == `FPG_IDX_IRQ_EN) begin
                irq_en_r <= pwdata[7:0];
            end
        end
    end

    // Read mux, evaluated in the setup phase
    // Unmapped index reads zero and flags an error
    // Clear register is write-only and reads zero
    always @* begin
        prdata_nxt = 32'h0000_0000;
        hit_nxt = 1'b0;
        for (p = 0; p < 4; p = p + 1) begin
            if (idx == IDX_DATA[p*14 +: 14]) begin
                prdata_nxt = {24'h00_0000, port_rd_w[p*8 +: 8]};
                hit_nxt = 1'b1;
            end
            if (idx == IDX_DIR[p*14 +: 14]) begin
                prdata_nxt = {24'h00_0000, dir_r[p*8 +: 8]};
                hit_nxt = 1'b1;
            end
            if (idx == IDX_PU[p*14 +: 14]) begin
                prdata_nxt = {24'h00_0000, pu_r[p*8 +: 8]};
                hit_nxt = 1'b1;
            end
            if (idx == IDX_OD[p*14 +: 14]) begin
                prdata_nxt = {24'h00_0000, od_r[p*8 +: 8]};
                hit_nxt = 1'b1;
            end
            if (idx == IDX_DB[p*14 +: 14]) begin
                prdata_nxt = {24'h00_0000, db_r[p*8 +: 8]};
                hit_nxt = 1'b1;
            end
        end
        case (idx)
            `FPG_IDX_PCI: begin
                prdata_nxt = {24'h00_0000, pci_r};
                hit_nxt = 1'b1;
            end
            `FPG_IDX_ANALOG_SELECT_LOW: begin
                prdata_nxt = {24'h00_0000, analog_select_low_r};
                hit_nxt = 1'b1;
            end
            `FPG_IDX_ANALOG_SELECT_HIGH_I2C_ROUTE: begin
                prdata_nxt = {24'h00_0000, analog_select_high_i2c_route_r};
                hit_nxt = 1'b1;
            end
            `FPG_IDX_IRQ_STAT: begin
                prdata_nxt = {24'h00_0000, stat_r};
                hit_nxt = 1'b1;
            end
            `FPG_IDX_IRQ_EN: begin
                prdata_nxt = {24'h00_0000, irq_en_r};
                hit_nxt = 1'b1;
            end
            `FPG_IDX_IRQ_CLR: begin
                hit_nxt = 1'b1;
            end
            default: begin
                hit_nxt = hit_nxt;
            end
        endcase
    end

    // One fixed access cycle; answer registered so outputs stay glitch free
    // Costs nothing in wait states since the access phase is always needed
    always @(posedge clk_sys) begin
        if (!rstn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            prdata <= pwrite ? 32'h0000_0000 : prdata_nxt;
            pready <= 1'b1;
            pslverr <= !hit_nxt;
        end else begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // Pad drive: open-drain only pulls low, never drives high
    // Outputs lag the registers by one edge
    always @(posedge clk_sys) begin
        if (!rstn) begin
            pin_out_r <= `FPG_RST_PORT;
            pin_oe_r <= `FPG_RST_PORT;
            pin_pullup_r <= `FPG_RST_PORT;
            pin_ibuf_off_r <= `FPG_RST_PORT;
            analog_channel_r <= 15'h0000;
            i2c_alt_route_r <= 1'b0;
        end else begin
            pin_out_r <= data_r & ~od_r;
            pin_oe_r <= dir_r & ~(od_r & data_r);
            pin_pullup_r <= pu_r;
            pin_ibuf_off_r <= cut_w;
            analog_channel_r <= {analog_select_high_i2c_route_r[6:0], analog_select_low_r};
            i2c_alt_route_r <= analog_select_high_i2c_route_r[`FPG_ANALOG_SELECT_HIGH_I2C_ROUTE_I2C];
        end
    end

endmodule

// ---- test/fpg_monitor.sv ----
`timescale 1ns/1ps
`include "fpg_defs.vh"
module fpg_monitor (
    input wire clk_sys,
    input wire rstn,
    input wire [15:0] paddr,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] pwdata,
    input wire pready,
    input wire [31:0] pin_oe_r,
    input wire [31:0] pin_pullup_r,
    input wire [31:0] pin_ibuf_off_r,
    input wire [14:0] analog_channel_r,
    input wire i2c_alt_route_r,
    input wire irq_r
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    wire [13:0] idx = paddr[15:2];
    wire wacc = psel && penable && pready && pwrite;
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence wr_s(logic [13:0] i);
        wacc && idx == i;
    endsequence
    AST_READY_AFTER_SETUP: assert property (setup_s |=> pready)
        else $error("no ready after setup");
    AST_READY_ONE: assert property (pready |=> !pready)
        else $error("ready held too long");
    AST_RESET_CLEAR: assert property ($rose(rstn) |-> !pin_oe_r && !pin_pullup_r && !irq_r)
        else $error("outputs not clear after reset");
    AST_PULLUP_P0: assert property (wr_s(`FPG_IDX_P0_PU)
        |-> ##2 pin_pullup_r[7:0] == $past(pwdata[7:0], 2))
        else $error("pull-up not applied");
    AST_DIR_P1: assert property (wr_s(`FPG_IDX_P1_DIR)
        |-> ##2 pin_oe_r[15:8] == $past(pwdata[7:0], 2))
        else $error("direction not applied");
    AST_ANALOG_SELECT_LOW: assert property (wr_s(`FPG_IDX_ANALOG_SELECT_LOW) |-> ##2 analog_channel_r[7:0]
        == $past(pwdata[7:0], 2) && pin_ibuf_off_r[7:0] == $past(pwdata[7:0], 2))
        else $error("low analog select wrong");
    AST_ANALOG_SELECT_HIGH_I2C_ROUTE: assert property (wr_s(`FPG_IDX_ANALOG_SELECT_HIGH_I2C_ROUTE) |-> ##2
        {i2c_alt_route_r, analog_channel_r[14:8]} == $past(pwdata[7:0], 2) &&
        pin_ibuf_off_r[`FPG_AN8_PIN] == $past(pwdata[0], 2))
        else $error("high analog select wrong");
    AST_IRQ_MASKED: assert property (wr_s(`FPG_IDX_IRQ_EN) && pwdata[7:0] == 8'h00
        |-> ##2 !irq_r)
        else $error("masked interrupt still high");
endmodule

// ---- test/fpg_pins.sv ----
`timescale 1ns/1ps
module fpg_pins (
    input wire clk_sys,
    input wire [31:0] drv_val,
    input wire [31:0] drv_en,
    input wire [31:0] pu_en,
    input wire [31:0] ext_val,
    input wire [31:0] ext_en,
    output wire [31:0] pin_lvl
);
    logic [31:0] float_r = 32'h0;
    // Floating lines wander so a stale level never passes
    always @(posedge clk_sys) float_r <= ~float_r;
    assign pin_lvl = (drv_en & drv_val) | (~drv_en & ext_en & ext_val)
        | (~drv_en & ~ext_en & (pu_en | float_r));
endmodule

// ---- test/testbench.sv ----
`timescale 1ns/1ps
`include "fpg_defs.vh"
module testbench;
    logic clk_sys = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic ext_reset_mode = 1'b0, irq_ack = 1'b0, err;
    logic [15:0] paddr = 16'h0;
    logic [31:0] pwdata = 32'h0, ext_val = 32'h0, ext_en = 32'hFFFF_FFFF, rd;
    wire [31:0] prdata, pin_in, pin_out_r, pin_oe_r, pin_pullup_r, pin_ibuf_off_r;
    wire [14:0] analog_channel_r;
    wire pready, pslverr, i2c_alt_route_r, irq_r;
    int bad_count = 0, checked = 0, cyc = 0;
    logic [13:0] ri [14] = '{`FPG_IDX_PCI, `FPG_IDX_P0_PU, `FPG_IDX_P1_PU, `FPG_IDX_P2_PU,
        `FPG_IDX_P3_PU, `FPG_IDX_P0_OD, `FPG_IDX_P3_OD, `FPG_IDX_P0_DB, `FPG_IDX_P2_DB,
        `FPG_IDX_P3_DB, `FPG_IDX_ANALOG_SELECT_LOW, `FPG_IDX_ANALOG_SELECT_HIGH_I2C_ROUTE, `FPG_IDX_IRQ_EN, `FPG_IDX_P0_DIR};
    fpg_top #(.DB_CYC(4), .DB_RST_CYC(6)) dut (.*);
    fpg_pins pins (.clk_sys(clk_sys), .drv_val(pin_out_r), .drv_en(pin_oe_r),
        .pu_en(pin_pullup_r), .ext_val(ext_val), .ext_en(ext_en), .pin_lvl(pin_in));
    initial begin
        forever #2.5 clk_sys = ~clk_sys;
    end
    task complete_run();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Run is about 260 cycles
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc > 5000) begin
            bad_count++;
            complete_run();
        end
    end
    task chk(input string nm, input [31:0] e, input [31:0] g);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task apb(input w, input [13:0] i, input [7:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {i, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1) begin
            @(posedge clk_sys);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask
    task wr(input [13:0] i, input [7:0] d);
        apb(1'b1, i, d);
    endtask
    task rdc(input [13:0] i, input [7:0] e, input string nm);
        apb(1'b0, i, 8'h00);
        chk(nm, {24'h0, e}, rd);
    endtask
    task wirq(input v);
        int n;
        n = 0;
        while (irq_r !== v && n < 30) begin
            @(posedge clk_sys);
            n++;
        end
        chk("irq", {31'h0, v}, {31'h0, irq_r});
    endtask
    task do_reset();
        rstn <= 1'b0;
        repeat (3) @(posedge clk_sys);
        rstn <= 1'b1;
        @(posedge clk_sys);
    endtask
    initial begin
        do_reset();
        for (int k = 0; k < 14; k++) begin
            rdc(ri[k], ri[k] == `FPG_IDX_P2_DB ? 8'h04 : 8'h00, "reset");
            wr(ri[k], 8'(8'h11 * (k + 1)));
            rdc(ri[k], 8'(8'h11 * (k + 1)), "readback");
        end
        do_reset();
        apb(1'b0, 14'h0001, 8'h00);
        chk("unmapped", 32'h1, {31'h0, err});
        ext_val[15:8] <= 8'h3C;
        repeat (4) @(posedge clk_sys);
        rdc(`FPG_IDX_P1_DATA, 8'h3C, "p1 in");
        wr(`FPG_IDX_P1_DIR, 8'hFF);
        wr(`FPG_IDX_P1_DATA, 8'hA5);
        rdc(`FPG_IDX_P1_DATA, 8'hA5, "p1 out");
        wr(`FPG_IDX_P1_DIR, 8'h00);
        wr(`FPG_IDX_P1_DB, 8'h01);
        ext_val[8] <= 1'b1;
        repeat (2) @(posedge clk_sys);
        ext_val[8] <= 1'b0;
        repeat (10) @(posedge clk_sys);
        rdc(`FPG_IDX_P1_DATA, 8'h3C, "glitch");
        ext_val[8] <= 1'b1;
        repeat (10) @(posedge clk_sys);
        rdc(`FPG_IDX_P1_DATA, 8'h3D, "steady");
        // Five cycles passes the short filter but not the long one
        ext_reset_mode <= 1'b1;
        ext_val[18] <= 1'b1;
        repeat (5) @(posedge clk_sys);
        ext_val[18] <= 1'b0;
        repeat (12) @(posedge clk_sys);
        rdc(`FPG_IDX_P2_DATA, 8'h00, "rst pin");
        wr(`FPG_IDX_P3_DIR, 8'hFF);
        wr(`FPG_IDX_P3_DATA, 8'h0F);
        wr(`FPG_IDX_P3_OD, 8'hFF);
        @(posedge clk_sys);
        chk("od out", 32'h0, pin_out_r & 32'hFF00_0000);
        chk("od oe", 32'hF000_0000, pin_oe_r & 32'hFF00_0000);
        wr(`FPG_IDX_ANALOG_SELECT_LOW, 8'h01);
        rdc(`FPG_IDX_P0_DATA, 8'h01, "analog");
        wr(`FPG_IDX_PCI, 8'h02);
        wr(`FPG_IDX_IRQ_EN, 8'h02);
        ext_val[2:1] <= 2'b11;
        wirq(1'b1);
        rdc(`FPG_IDX_IRQ_STAT, 8'h02, "status");
        wr(`FPG_IDX_IRQ_CLR, 8'h02);
        wirq(1'b0);
        ext_val[1] <= 1'b0;
        wirq(1'b1);
        wr(`FPG_IDX_IRQ_EN, 8'h00);
        wirq(1'b0);
        wr(`FPG_IDX_IRQ_EN, 8'h02);
        wirq(1'b1);
        irq_ack <= 1'b1;
        @(posedge clk_sys);
        irq_ack <= 1'b0;
        wirq(1'b0);
        complete_run();
    end
endmodule
bind fpg_top fpg_monitor mon (.*);
